/* rtl/srs_defs.svh */
// Offsets, field positions, reset values and timing counts of the relay signaling block
`ifndef SRS_DEFS_SVH
`define SRS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SRS_OFF_CTRL 12'h000
`define SRS_OFF_STATUS 12'h004
`define SRS_OFF_RESV 12'h008
`define SRS_OFF_RELAY 12'h00C
`define SRS_OFF_RSTAGE 12'h010
`define SRS_OFF_RACTIVE 12'h014
`define SRS_OFF_OFFS_BASE 12'h020
`define SRS_OFF_SLOT_BASE 12'h040

// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define SRS_CTRL_SETUP_EN 0
`define SRS_CTRL_APPLY 1
`define SRS_CTRL_REINIT 2
`define SRS_CTRL_SEL_LO 4
`define SRS_STAT_SETUP_ACT 0
`define SRS_STAT_REINIT 1
`define SRS_STAT_APPLIED 2

// ----------------------------------------------------------------
// Slot configuration fields
// ----------------------------------------------------------------
`define SRS_SLOT_ASSIGN 0
`define SRS_SLOT_MODE 1
`define SRS_SLOT_LONG 2
`define SRS_SLOT_PRESET 3
`define SRS_SLOT_EN_LO 4
`define SRS_SLOT_EN_HI 8
`define SRS_SLOT_REL_LO 16
`define SRS_SLOT_CARD_HI 23
`define SRS_FS_MASK 5'h1C

// ----------------------------------------------------------------
// Reset values, offset limits and timing
// ----------------------------------------------------------------
`define SRS_RESV_RST 32'h0000_0000
`define SRS_OFFS_MIN (-40)
`define SRS_OFFS_MAX 20
`define SRS_CLK_HZ 100000000
`define SRS_PULSE_SHORT_MS 100
`define SRS_PULSE_LONG_MS 200

`endif

/* rtl/srs_pkg.sv */
// Types shared by the relay signaling block
package srs_pkg;
  typedef logic [31:0] srs_word_t;
  typedef enum logic {srs_p_idle, srs_p_high} srs_pstate_t;
endpackage

/* rtl/srs_pulse.sv */
// Impulse timer for one relay slot
`timescale 1ns/1ps
`include "srs_defs.svh"
module srs_pulse #(
  parameter int SHORT_CYC = `SRS_PULSE_SHORT_MS * (`SRS_CLK_HZ / 1000),
  parameter int LONG_CYC = `SRS_PULSE_LONG_MS * (`SRS_CLK_HZ / 1000)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic trig,
  input wire logic long_sel,
  output logic pulse
);
  import srs_pkg::*;

  srs_pstate_t state_r;
  logic trig_q_r;
  logic [31:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q_r <= 1'b0;
    end else if (ce) begin
      trig_q_r <= trig;
    end
  end

  // Retrigger while high is ignored so the closure time stays exact
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= srs_p_idle;
      cnt_r <= 32'h0000_0000;
    end else if (ce) begin
      case (state_r)
        srs_p_idle: begin
          if (trig && !trig_q_r) begin
            state_r <= srs_p_high;
            cnt_r <= long_sel ? 32'(LONG_CYC - 1) : 32'(SHORT_CYC - 1);
          end
        end
        srs_p_high: begin
          if (cnt_r == 32'h0000_0000) begin
            state_r <= srs_p_idle;
          end else begin
            cnt_r <= cnt_r - 32'h0000_0001;
          end
        end
        default: begin
          state_r <= srs_p_idle;
        end
      endcase
    end
  end

  assign pulse = (state_r == srs_p_high);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [31:0] hi_cnt_r;
  logic [31:0] len_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt_r <= 32'h0000_0000;
      len_r <= 32'h0000_0000;
    end else if (ce) begin
      hi_cnt_r <= pulse ? hi_cnt_r + 32'h0000_0001 : 32'h0000_0000;
      if (state_r == srs_p_idle && trig && !trig_q_r) begin
        len_r <= long_sel ? 32'(LONG_CYC) : 32'(SHORT_CYC);
      end
    end
  end

  chk_pulse_len: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pulse && cnt_r == 32'h0000_0000) |-> (hi_cnt_r + 32'h0000_0001 == len_r))
    else $error("impulse closure length wrong");

  chk_pulse_edge: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pulse) |-> ($past(trig) && !$past(trig_q_r)))
    else $error("impulse started without a rising trigger");
endmodule

/* rtl/srs_top.sv */
// Relay signaling and monitor setup block with APB register access
//
// Operation
// - Every source owns four relay slots, numbered 0 to 3, each bound to one relay or unassigned.
// - Each slot picks latching or impulse mode on its own.
// - A latching slot keeps its relay closed exactly while its trigger holds.
// - An impulse slot closes its relay for 100 ms or 200 ms when its trigger comes true, then opens it.
// - A relay shared by several slots is driven by the OR of their results.
// - All enabled conditions of a slot are ANDed together.
// - A slot fires only while its source is patched into a channel.
// - Five optional conditions exist: user key 1, user key 2, input selector, channel on, fader open.
// - A fader start preset enables input selector, channel on and fader open; the slot's own enable bits are ignored while it is set.
// - Relays are addressed by card number and relay number, sixteen to a card.
// - Relays reserved for system functions can not be driven by slots.
// - Conditions come from whatever channel the source is patched to.
// - Speaker level offsets range -20 dB to +10 dB in half dB steps and are shown on the panel.
// - The setup key works only while setup mode is enabled.
// - Monitor outputs are muted while a reinitialisation runs.
// - Edited monitor routing takes effect only after an apply command.
`timescale 1ns/1ps
`include "srs_defs.svh"
module srs_top #(
  parameter int NUM_SRC = 4,
  parameter int SLOTS = 4,
  parameter int NUM_CH = 8,
  parameter int NUM_RELAY = 32,
  parameter int NUM_SPK = 4,
  parameter int SHORT_CYC = `SRS_PULSE_SHORT_MS * (`SRS_CLK_HZ / 1000),
  parameter int LONG_CYC = `SRS_PULSE_LONG_MS * (`SRS_CLK_HZ / 1000)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire srs_pkg::srs_word_t pwdata,
  output srs_pkg::srs_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_SRC-1:0] src_patched,
  input wire logic [$clog2(NUM_CH)-1:0] src_chan [NUM_SRC],
  input wire logic [NUM_CH-1:0] ch_key1,
  input wire logic [NUM_CH-1:0] ch_key2,
  input wire logic [NUM_CH-1:0] ch_on,
  input wire logic [NUM_CH-1:0] ch_fader_open,
  input wire logic [$clog2(NUM_SRC)-1:0] ch_insel_src [NUM_CH],
  input wire logic setup_key,
  input wire logic reinit_done,
  output logic [NUM_RELAY-1:0] relay_out,
  output logic mon_mute,
  output srs_pkg::srs_word_t mon_route,
  output logic [6:0] mon_disp_offset,
  output logic mon_disp_valid,
  output logic [NUM_SPK*7-1:0] mon_offsets
);
  import srs_pkg::*;

  localparam int NSLOT = NUM_SRC * SLOTS;
  localparam int CHW = $clog2(NUM_CH);
  localparam int SW = $clog2(NUM_SRC);
  localparam int RW = $clog2(NUM_RELAY);
  localparam int PW = $clog2(NUM_SPK);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] slot_cfg_r [NSLOT];
  logic [6:0] offs_r [NUM_SPK];
  logic setup_en_r;
  logic [PW-1:0] spk_sel_r;
  logic [NUM_RELAY-1:0] resv_mask_r;
  logic [NUM_RELAY-1:0] relay_r;
  logic [NUM_RELAY-1:0] relay_nxt;
  srs_word_t rstage_r;
  srs_word_t ractive_r;
  logic reinit_r;
  logic key_s1_r;
  logic key_s2_r;
  logic setup_active;
  srs_word_t prdata_r;
  logic pslverr_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_setup;
  logic [9:0] widx;
  logic is_slot;
  logic is_offs;
  logic is_fixed;
  logic [9:0] slot_i;
  logic [9:0] offs_i;
  logic apply_cmd;
  logic reinit_cmd;

  assign wr_en = ce && psel && penable && pwrite;
  assign rd_setup = ce && psel && !penable;
  assign widx = paddr[11:2];
  assign slot_i = widx - 10'(`SRS_OFF_SLOT_BASE >> 2);
  assign offs_i = widx - 10'(`SRS_OFF_OFFS_BASE >> 2);
  assign is_slot = (paddr >= `SRS_OFF_SLOT_BASE) && (slot_i < 10'(NSLOT));
  assign is_offs = (paddr >= `SRS_OFF_OFFS_BASE) && (offs_i < 10'(NUM_SPK));
  assign is_fixed = (paddr <= `SRS_OFF_RACTIVE);
  assign apply_cmd = wr_en && paddr == `SRS_OFF_CTRL && pwdata[`SRS_CTRL_APPLY];
  assign reinit_cmd = wr_en && paddr == `SRS_OFF_CTRL && pwdata[`SRS_CTRL_REINIT];

  // Zero wait states: read data is latched in the setup cycle
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (rd_setup) begin
      pslverr_r <= !(is_slot || is_offs || is_fixed);
      prdata_r <= 32'h0000_0000;
      if (is_slot) begin
        prdata_r <= slot_cfg_r[slot_i[$clog2(NSLOT)-1:0]];
      end else if (is_offs) begin
        prdata_r <= {25'h000_0000, offs_r[offs_i[PW-1:0]]};
      end else begin
        case (paddr)
          `SRS_OFF_CTRL: prdata_r <= 32'({spk_sel_r, 3'b000, setup_en_r}) ;
          `SRS_OFF_STATUS: prdata_r <= {29'h0000_0000, rstage_r == ractive_r, reinit_r, setup_active};
          `SRS_OFF_RESV: prdata_r <= 32'(resv_mask_r);
          `SRS_OFF_RELAY: prdata_r <= 32'(relay_r);
          `SRS_OFF_RSTAGE: prdata_r <= rstage_r;
          `SRS_OFF_RACTIVE: prdata_r <= ractive_r;
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NSLOT; i++) begin
        slot_cfg_r[i] <= 32'h0000_0000;
      end
    end else if (wr_en && is_slot) begin
      slot_cfg_r[slot_i[$clog2(NSLOT)-1:0]] <= pwdata & 32'h00FF_01FF;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_en_r <= 1'b0;
      spk_sel_r <= '0;
      resv_mask_r <= NUM_RELAY'(`SRS_RESV_RST);
      rstage_r <= 32'h0000_0000;
    end else if (wr_en) begin
      if (paddr == `SRS_OFF_CTRL) begin
        setup_en_r <= pwdata[`SRS_CTRL_SETUP_EN];
        spk_sel_r <= pwdata[`SRS_CTRL_SEL_LO +: PW];
      end
      if (paddr == `SRS_OFF_RESV) begin
        resv_mask_r <= pwdata[NUM_RELAY-1:0];
      end
      if (paddr == `SRS_OFF_RSTAGE) begin
        rstage_r <= pwdata;
      end
    end
  end

  // Edited routing stays staged until apply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ractive_r <= 32'h0000_0000;
    end else if (apply_cmd) begin
      ractive_r <= rstage_r;
    end
  end

  // Set wins over the done strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reinit_r <= 1'b0;
    end else if (ce) begin
      if (reinit_cmd) begin
        reinit_r <= 1'b1;
      end else if (reinit_done) begin
        reinit_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Monitor setup key and level offsets
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_s1_r <= 1'b0;
      key_s2_r <= 1'b0;
    end else if (ce) begin
      key_s1_r <= setup_key;
      key_s2_r <= key_s1_r;
    end
  end

  assign setup_active = setup_en_r && key_s2_r;

  // Half dB units cover both step sizes
  function automatic logic [6:0] clamp_offs(input logic [6:0] v);
    logic signed [6:0] s;
    s = signed'(v);
    if (s < 7'(`SRS_OFFS_MIN)) begin
      return 7'(`SRS_OFFS_MIN);
    end else if (s > 7'(`SRS_OFFS_MAX)) begin
      return 7'(`SRS_OFFS_MAX);
    end
    return v;
  endfunction

  for (genvar p = 0; p < NUM_SPK; p++) begin : g_spk
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        offs_r[p] <= 7'h00;
      end else if (wr_en && is_offs && offs_i == 10'(p) && setup_active) begin
        offs_r[p] <= clamp_offs(pwdata[6:0]);
      end
    end
    assign mon_offsets[p*7 +: 7] = offs_r[p];

    chk_offs_range: assert property (@(posedge pclk) disable iff (!presetn)
      (signed'(offs_r[p]) >= 7'sd0 - 7'sd40) && (signed'(offs_r[p]) <= 7'sd20))
      else $error("speaker offset out of range");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_disp_offset <= 7'h00;
      mon_disp_valid <= 1'b0;
    end else if (ce) begin
      mon_disp_offset <= offs_r[spk_sel_r];
      mon_disp_valid <= setup_active;
    end
  end

  assign mon_mute = reinit_r;
  assign mon_route = ractive_r;

  // ----------------------------------------------------------------
  // Relay slots
  // ----------------------------------------------------------------
  logic [NSLOT-1:0] slot_drive;
  logic [NSLOT-1:0] slot_ok;
  logic [RW-1:0] slot_idx [NSLOT];

  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    localparam int SRC = s / SLOTS;
    logic [31:0] cfg;
    logic [CHW-1:0] ch;
    logic [4:0] cond;
    logic [4:0] en;
    logic [7:0] ridx;
    logic rvalid;
    logic trig;
    logic pulse;

    assign cfg = slot_cfg_r[s];
    assign ch = src_chan[SRC];
    assign cond = {ch_fader_open[ch], ch_on[ch], ch_insel_src[ch] == SW'(SRC), ch_key2[ch], ch_key1[ch]};
    assign en = cfg[`SRS_SLOT_PRESET] ? `SRS_FS_MASK : cfg[`SRS_SLOT_EN_HI:`SRS_SLOT_EN_LO];
    assign ridx = cfg[`SRS_SLOT_CARD_HI:`SRS_SLOT_REL_LO];
    assign rvalid = cfg[`SRS_SLOT_ASSIGN] && (ridx < 8'(NUM_RELAY)) && !resv_mask_r[ridx[RW-1:0]];
    assign trig = rvalid && src_patched[SRC] && ((en & ~cond) == 5'h00);

    srs_pulse #(
      .SHORT_CYC(SHORT_CYC),
      .LONG_CYC(LONG_CYC)
    ) u_pulse (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .trig(trig && cfg[`SRS_SLOT_MODE]),
      .long_sel(cfg[`SRS_SLOT_LONG]),
      .pulse(pulse)
    );

    assign slot_drive[s] = cfg[`SRS_SLOT_MODE] ? pulse : trig;
    assign slot_ok[s] = rvalid;
    assign slot_idx[s] = ridx[RW-1:0];

    chk_slot_and: assert property (@(posedge pclk) disable iff (!presetn)
      trig |-> (src_patched[SRC] && cfg[`SRS_SLOT_ASSIGN] && (!en[0] || ch_key1[ch]) && (!en[1] || ch_key2[ch])
        && (!en[2] || ch_insel_src[ch] == SW'(SRC)) && (!en[3] || ch_on[ch]) && (!en[4] || ch_fader_open[ch])))
      else $error("slot fired with a condition missing");

    chk_slot_preset: assert property (@(posedge pclk) disable iff (!presetn)
      cfg[`SRS_SLOT_PRESET] |-> (en == 5'h1C))
      else $error("fader start preset mask wrong");
  end

  // A relay shared by many slots sees the OR of all of them
  always_comb begin
    relay_nxt = '0;
    for (int s = 0; s < NSLOT; s++) begin
      if (slot_ok[s] && slot_drive[s]) begin
        relay_nxt[slot_idx[s]] = 1'b1;
      end
    end
    relay_nxt = relay_nxt & ~resv_mask_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_r <= '0;
    end else if (ce) begin
      relay_r <= relay_nxt;
    end
  end

  assign relay_out = relay_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_relay_or: assert property (@(posedge pclk) disable iff (!presetn)
    ce ##1 1'b1 |-> relay_out == $past(relay_nxt))
    else $error("relay does not follow slot OR");

  chk_resv_block: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(resv_mask_r) |-> ((relay_out & resv_mask_r) == '0))
    else $error("reserved relay driven");

  chk_setup_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (!setup_en_r && wr_en && is_offs) |=> $stable(mon_offsets))
    else $error("offset taken without setup mode");

  chk_reinit_mute: assert property (@(posedge pclk) disable iff (!presetn)
    reinit_cmd |=> mon_mute)
    else $error("monitors not muted during reinit");

  chk_apply_only: assert property (@(posedge pclk) disable iff (!presetn)
    !$stable(mon_route) |-> $past(apply_cmd))
    else $error("routing changed without apply");
endmodule

/* tb/srs_relay_load.sv */
// Behavioural load on the relay contacts, measuring every closure
`timescale 1ns/1ps
module srs_relay_load #(
  parameter int N = 32
) (
  input wire logic pclk,
  input wire logic [N-1:0] relay_out,
  output int last_len [N],
  output int closures [N]
);
  int run [N];

  initial begin
    for (int i = 0; i < N; i++) begin
      run[i] = 0;
      last_len[i] = 0;
      closures[i] = 0;
    end
  end

  // ----------------------------------------
  // Closure timing
  // ----------------------------------------
  // Counted in whole clocks; a contact that never opens keeps its old length
  always @(posedge pclk) begin
    for (int i = 0; i < N; i++) begin
      if (relay_out[i] === 1'b1) begin
        if (run[i] == 0) begin
          closures[i]++;
        end
        run[i]++;
      end else if (run[i] != 0) begin
        last_len[i] = run[i];
        run[i] = 0;
      end
    end
  end
endmodule

/* tb/test_source_relay_signaling.sv */
// Self-checking bench of the relay signaling block over APB
`timescale 1ns/1ps
module test_source_relay_signaling;
  import srs_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic ce = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  srs_word_t pwdata = 0;
  srs_word_t prdata;
  logic pready;
  logic pslverr;
  logic [3:0] src_patched = 0;
  logic [2:0] src_chan [4];
  logic [7:0] ch_key1 = 0;
  logic [7:0] ch_key2 = 0;
  logic [7:0] ch_on = 0;
  logic [7:0] ch_fader_open = 0;
  logic [1:0] ch_insel_src [8];
  logic setup_key = 0;
  logic reinit_done = 0;
  logic [31:0] relay_out;
  logic mon_mute;
  srs_word_t mon_route;
  logic [6:0] mon_disp_offset;
  logic mon_disp_valid;
  logic [27:0] mon_offsets;
  int last_len [32];
  int closures [32];
  int errors = 0;
  int compares = 0;
  srs_word_t rd;
  logic er;

  always #5 pclk = ~pclk;

  // Short pulse counts keep the impulse scenarios brief
  srs_top #(.SHORT_CYC(5), .LONG_CYC(10)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_patched(src_patched), .src_chan(src_chan), .ch_key1(ch_key1), .ch_key2(ch_key2),
    .ch_on(ch_on), .ch_fader_open(ch_fader_open), .ch_insel_src(ch_insel_src),
    .setup_key(setup_key), .reinit_done(reinit_done), .relay_out(relay_out), .mon_mute(mon_mute),
    .mon_route(mon_route), .mon_disp_offset(mon_disp_offset), .mon_disp_valid(mon_disp_valid),
    .mon_offsets(mon_offsets)
  );

  srs_relay_load #(.N(32)) load (.pclk(pclk), .relay_out(relay_out), .last_len(last_len), .closures(closures));

  // ----------------------------------------
  // Access and check tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Starts one edge later so psel is never driven twice in one time step
  task automatic apb(input logic [11:0] a, input logic w, input srs_word_t d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input srs_word_t e, input string nm);
    apb(a, 1'b0, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  // Mask bits: key1, key2, input selector on source s, channel on, fader open
  task automatic cond(input int c, input logic [4:0] m, input logic [1:0] s);
    @(posedge pclk);
    ch_key1[c] <= m[0];
    ch_key2[c] <= m[1];
    ch_insel_src[c] <= m[2] ? s : s + 2'd1;
    ch_on[c] <= m[3];
    ch_fader_open[c] <= m[4];
  endtask

  task automatic settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  task automatic rly(input int i, input logic e, input string nm);
    settle();
    chk(nm, 32'(e), 32'(relay_out[i]));
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 4; i++) begin
      src_chan[i] = 3'd0;
    end
    for (int i = 0; i < 8; i++) begin
      ch_insel_src[i] = 2'd0;
    end
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'h000, 32'h0000_0000, "ctrl reset");
    rdchk(12'h008, 32'h0000_0000, "resv reset");
    rdchk(12'h00C, 32'h0000_0000, "relay reset");
    apb(12'h01C, 1'b0, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, 32'(er));
    apb(12'h010, 1'b1, 32'h1234_5678);
    chk("route early", 32'h0000_0000, mon_route);
    rdchk(12'h014, 32'h0000_0000, "active early");
    apb(12'h000, 1'b1, 32'h0000_0002);
    settle();
    chk("route applied", 32'h1234_5678, mon_route);
    apb(12'h000, 1'b1, 32'h0000_0004);
    settle();
    chk("mute busy", 32'h0000_0001, 32'(mon_mute));
    @(posedge pclk);
    reinit_done <= 1'b1;
    @(posedge pclk);
    reinit_done <= 1'b0;
    settle();
    chk("mute done", 32'h0000_0000, 32'(mon_mute));
    apb(12'h020, 1'b1, 32'h0000_0010);
    rdchk(12'h020, 32'h0000_0000, "offset locked");
    apb(12'h000, 1'b1, 32'h0000_0001);
    setup_key <= 1'b1;
    settle();
    chk("setup valid", 32'h0000_0001, 32'(mon_disp_valid));
    apb(12'h020, 1'b1, 32'h0000_0010);
    rdchk(12'h020, 32'h0000_0010, "offset mid");
    apb(12'h024, 1'b1, 32'hFFFF_FFCE);
    rdchk(12'h024, 32'h0000_0058, "offset floor");
    apb(12'h028, 1'b1, 32'h0000_001E);
    rdchk(12'h028, 32'h0000_0014, "offset ceiling");
    chk("offset pins", 32'h0005_2C10, 32'(mon_offsets));
    chk("offset shown", 32'h0000_0010, 32'(mon_disp_offset));
    apb(12'h000, 1'b1, 32'h0000_0021);
    settle();
    chk("offset shown sel", 32'h0000_0014, 32'(mon_disp_offset));
    rdchk(12'h004, 32'h0000_0005, "status setup");
    setup_key <= 1'b0;
    src_patched <= 4'hF;
    src_chan[0] <= 3'd2;
    src_chan[1] <= 3'd6;
    src_chan[2] <= 3'd1;
    src_chan[3] <= 3'd3;
    settle();
    apb(12'h020, 1'b1, 32'h0000_0002);
    rdchk(12'h020, 32'h0000_0010, "offset key up");
    // Relay 18 is card 1, relay 2
    for (int i = 0; i < 5; i++) begin
      apb(12'h040, 1'b1, 32'h0012_0001 | (32'h0000_0010 << i));
      cond(2, 5'h1F ^ (5'h01 << i), 2'd0);
      rly(18, 1'b0, "lone cond off");
      cond(2, 5'h01 << i, 2'd0);
      rly(18, 1'b1, "lone cond on");
    end
    apb(12'h040, 1'b1, 32'h0012_0111);
    cond(2, 5'h01, 2'd0);
    rly(18, 1'b0, "and partial");
    cond(2, 5'h11, 2'd0);
    rly(18, 1'b1, "and full");
    @(posedge pclk);
    src_patched <= 4'hE;
    rly(18, 1'b0, "unpatched");
    @(posedge pclk);
    src_patched <= 4'hF;
    src_chan[0] <= 3'd5;
    rly(18, 1'b0, "repatched idle");
    cond(5, 5'h11, 2'd0);
    rly(18, 1'b1, "repatched live");
    apb(12'h054, 1'b1, 32'h0012_0021);
    cond(6, 5'h02, 2'd1);
    cond(5, 5'h00, 2'd0);
    rly(18, 1'b1, "shared relay");
    apb(12'h008, 1'b1, 32'h0004_0000);
    rly(18, 1'b0, "reserved relay");
    apb(12'h008, 1'b1, 32'h0000_0000);
    rly(18, 1'b1, "released relay");
    apb(12'h054, 1'b1, 32'h0012_0020);
    rly(18, 1'b0, "unassigned slot");
    apb(12'h070, 1'b1, 32'h0007_0009);
    cond(3, 5'h0C, 2'd3);
    rly(7, 1'b0, "preset no fader");
    cond(3, 5'h1C, 2'd3);
    rly(7, 1'b1, "preset full");
    @(posedge pclk);
    ce <= 1'b0;
    cond(3, 5'h0C, 2'd3);
    rly(7, 1'b1, "frozen relay");
    @(posedge pclk);
    ce <= 1'b1;
    rly(7, 1'b0, "thawed relay");
    for (int k = 0; k < 2; k++) begin
      apb(12'h06C, 1'b1, 32'h0005_0043 | (32'(k) << 2));
      cond(1, 5'h04, 2'd2);
      repeat (40) @(posedge pclk);
      #1;
      chk("pulse length", (k == 0) ? 32'd5 : 32'd10, 32'(last_len[5]));
      chk("pulse count", 32'(k + 1), 32'(closures[5]));
      cond(1, 5'h00, 2'd2);
    end
    settle();
    tally_and_finish();
  end
endmodule
